/* logic/pdm_mode_ctrl.sv */
// Serial load, power save, phase output and monitor control of the PLL
`timescale 1ns/1ps
module pdm_mode_ctrl
(
   input  wire logic        i_clk_sys,                    // 10 MHz system clock
   input  wire logic        i_arst_n,                     // Async reset, active low
   // Serial programming pins
   input  wire logic        i_ser_clk,                    // Serial shift clock
   input  wire logic        i_ser_data,                   // Serial data, MSB first
   input  wire logic        i_load_enable_pin,            // Latch while high
   // Mode pins
   input  wire logic        i_power_save_pin_n,           // Low = power save
   input  wire logic        i_pump_output_disable_pin_n,  // Low = pump floats
   // Divided frequencies from the counters
   input  wire logic        i_divided_reference_freq,     // Divided reference
   input  wire logic        i_divided_comparison_freq,    // Divided comparison
   // Charge pump, tri-state
   output logic             o_pump,                       // Pump level
   output logic             o_pump_oe_n,                  // Low while driving
   // Phase comparator outputs
   output logic             o_phase_ref,                  // Push-pull output
   output logic             o_phase_cmp,                  // Open drain, always low
   output logic             o_phase_cmp_oe_n,             // Low while pulling down
   output logic             o_lock_or_monitor_pin,        // Lock or monitor
   // Settings toward counters and prescaler
   output logic             o_prescaler_32,               // 1 = 32/33, 0 = 64/65
   output logic [13:0]      o_ref_ratio,                  // Reference divide ratio
   output logic [6:0]       o_swallow,                    // Swallow count
   output logic [10:0]      o_prog_count,                 // Programmable count
   output logic             o_power_down,                 // Nonessential logic off
   // APB slave
   input  wire logic        i_psel,                       // Select
   input  wire logic        i_penable,                    // Access phase
   input  wire logic        i_pwrite,                     // Write direction
   input  wire logic [7:0]  i_paddr,                      // Byte address
   input  wire logic [31:0] i_pwdata,                     // Write data
   output logic [31:0]      o_prdata,                     // Read data
   output logic             o_pready,                     // Always ready
   output logic             o_pslverr                     // Unmapped or bad write
);

   ////////////////////////////////////////////////////////////////////////////////
   // Whole state of the block
   typedef struct packed
   {
      logic [pdm_pkg::SY_W-1:0]  s1;         // First sync stage
      logic [pdm_pkg::SY_W-1:0]  s2;         // Second sync stage
      logic [pdm_pkg::SY_W-1:0]  s3;         // Delayed copy for edges
      logic [pdm_pkg::SR_W-1:0]  sr;         // Serial shift register
      logic [pdm_pkg::REF_W-1:0] ref_lat;    // Reference latch
      logic [pdm_pkg::DIV_W-1:0] div_lat;    // Divider latch
      pdm_pkg::pdm_pwr_t         pwr;        // Power mode
      logic [15:0]               wcnt;       // Wake limit countdown
      logic [7:0]                lcnt;       // Quiet cycles for lock
      logic                      ctrl_limit; // Wake limit enable
      logic [15:0]               wake_len;   // Wake limit length
      logic [31:0]               prdata;     // Read data
      logic                      pslverr;    // Error answer
      logic                      pump;       // Pump level
      logic                      pump_oe_n;  // Pump enable
      logic                      phr;        // Reference output
      logic                      php_oe_n;   // Comparison output enable
      logic                      mon;        // Lock or monitor output
   } pdm_st_t;

   pdm_st_t  s_r;
   pdm_st_t  s_nxt;
   pdm_pd_if pd ();

   // Decoded views of the latched word, the power mode and the lock count
   logic fc;
   logic monitor_output_select;
   logic run;
   logic locked_c;
   assign fc       = s_r.ref_lat[pdm_pkg::REF_FC_BIT];
   assign monitor_output_select      = s_r.ref_lat[pdm_pkg::REF_LDS_BIT];
   assign run      = (s_r.pwr == pdm_pkg::PM_RUN);
   assign locked_c = (s_r.lcnt == pdm_pkg::LOCK_CYC);

   ////////////////////////////////////////////////////////////////////////////////
   // Detector edges from synchronised divided frequencies
   assign pd.ref_edge = s_r.s2[pdm_pkg::SY_FR] & ~s_r.s3[pdm_pkg::SY_FR];
   assign pd.cmp_edge = s_r.s2[pdm_pkg::SY_FP] & ~s_r.s3[pdm_pkg::SY_FP];
   assign pd.clr      = ~run;

   pdm_phase_det u_det
   (
      .i_clk_sys (i_clk_sys),
      .i_arst_n  (i_arst_n),
      .pd        (pd)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      logic sclk_rise;
      logic ref_lead_act;
      logic cmp_lead_act;
      logic wr;
      sclk_rise    = 1'b0;
      ref_lead_act = 1'b0;
      cmp_lead_act = 1'b0;
      wr           = 1'b0;
      s_nxt        = s_r;

      // Pins pass two flops; s1 feeds only s2
      s_nxt.s1 = {i_divided_comparison_freq, i_divided_reference_freq,
                  i_pump_output_disable_pin_n, i_power_save_pin_n,
                  i_load_enable_pin, i_ser_data, i_ser_clk};
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;

      // Shift on serial clock rise, in any power mode
      sclk_rise = s_r.s2[pdm_pkg::SY_SCLK] & ~s_r.s3[pdm_pkg::SY_SCLK];
      if (sclk_rise)
      begin
         s_nxt.sr = {s_r.sr[pdm_pkg::SR_W-2:0], s_r.s2[pdm_pkg::SY_DATA]};
      end

      // Latch while load enable is high, steered by the control bit
      if (s_r.s2[pdm_pkg::SY_LE])
      begin
         if (s_r.sr[0])
         begin
            s_nxt.ref_lat = s_r.sr[pdm_pkg::REF_W:1];
         end
         else
         begin
            s_nxt.div_lat = s_r.sr[pdm_pkg::DIV_W:1];
         end
      end

      // Power mode; a low pin wins from any state
      case (s_r.pwr)
         pdm_pkg::PM_SAVE:
         begin
            if (s_r.s2[pdm_pkg::SY_PS])
            begin
               s_nxt.pwr  = s_r.ctrl_limit ? pdm_pkg::PM_WAKE : pdm_pkg::PM_RUN;
               s_nxt.wcnt = s_r.wake_len;
            end
         end
         pdm_pkg::PM_WAKE:
         begin
            // Detector held idle so a random phase gives no error burst
            if (s_r.wcnt <= 16'h0001)
            begin
               s_nxt.pwr = pdm_pkg::PM_RUN;
            end
            s_nxt.wcnt = (s_r.wcnt == 16'h0000) ? 16'h0000 : s_r.wcnt - 16'h0001;
         end
         pdm_pkg::PM_RUN:
         begin
            s_nxt.pwr = pdm_pkg::PM_RUN;
         end
         default:
         begin
            s_nxt.pwr = pdm_pkg::PM_SAVE;
         end
      endcase
      if (!s_r.s2[pdm_pkg::SY_PS])
      begin
         s_nxt.pwr = pdm_pkg::PM_SAVE;
      end

      // Lock detect: quiet cycles saturate; locked outside run
      if (!run)
      begin
         s_nxt.lcnt = pdm_pkg::LOCK_CYC;
      end
      else if (pd.ref_lead | pd.cmp_lead)
      begin
         s_nxt.lcnt = 8'h00;
      end
      else if (!locked_c)
      begin
         s_nxt.lcnt = s_r.lcnt + 8'h01;
      end

      // Phase outputs; idle pattern when equal or not running
      ref_lead_act  = run & pd.ref_lead;
      cmp_lead_act  = run & pd.cmp_lead;
      s_nxt.pump    = fc ? ref_lead_act : cmp_lead_act;
      s_nxt.phr     = fc ? cmp_lead_act : ref_lead_act;
      s_nxt.php_oe_n = ~(fc ? ref_lead_act : cmp_lead_act);
      // Pump floats when equal, in save or wake, or disabled
      s_nxt.pump_oe_n = ~((ref_lead_act | cmp_lead_act)
                          & s_r.s2[pdm_pkg::SY_ZC]);

      // Lock or monitor select
      if (monitor_output_select)
      begin
         s_nxt.mon = fc ? s_r.s2[pdm_pkg::SY_FR] : s_r.s2[pdm_pkg::SY_FP];
      end
      else
      begin
         s_nxt.mon = locked_c | ~run;
      end

      // APB: decode at setup so read data comes from a flop
      if (i_psel & ~i_penable)
      begin
         s_nxt.prdata  = 32'h0000_0000;
         s_nxt.pslverr = 1'b0;
         case (i_paddr)
            pdm_pkg::OFF_CTRL:      s_nxt.prdata = {31'h0, s_r.ctrl_limit};
            pdm_pkg::OFF_WAKE_LEN:  s_nxt.prdata = {16'h0, s_r.wake_len};
            pdm_pkg::OFF_STATUS:
            begin
               s_nxt.prdata = {22'h0, s_r.pwr, locked_c, pd.ref_lead, pd.cmp_lead,
                               s_r.ref_lat[pdm_pkg::REF_LDS_BIT:pdm_pkg::REF_SW_BIT],
                               1'b0};
               s_nxt.pslverr = i_pwrite;
            end
            pdm_pkg::OFF_REF_LATCH:
            begin
               s_nxt.prdata  = {15'h0, s_r.ref_lat};
               s_nxt.pslverr = i_pwrite;
            end
            pdm_pkg::OFF_DIV_LATCH:
            begin
               s_nxt.prdata  = {14'h0, s_r.div_lat};
               s_nxt.pslverr = i_pwrite;
            end
            default:                s_nxt.pslverr = 1'b1;
         endcase
      end

      // Writes take effect at the access edge only
      wr = i_psel & i_penable & i_pwrite;
      if (wr && (i_paddr == pdm_pkg::OFF_CTRL))
      begin
         s_nxt.ctrl_limit = i_pwdata[pdm_pkg::CTRL_LIMIT_BIT];
      end
      if (wr && (i_paddr == pdm_pkg::OFF_WAKE_LEN))
      begin
         s_nxt.wake_len = i_pwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register; power-on starts in power save like the pin
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         s_r            <= '0;
         s_r.ref_lat    <= pdm_pkg::REF_RST;
         s_r.div_lat    <= pdm_pkg::DIV_RST;
         s_r.pwr        <= pdm_pkg::PM_SAVE;
         s_r.lcnt       <= pdm_pkg::LOCK_CYC;
         s_r.ctrl_limit <= pdm_pkg::CTRL_LIMIT_RST;
         s_r.wake_len   <= pdm_pkg::WAKE_CYC;
         s_r.pump_oe_n  <= 1'b1;
         s_r.php_oe_n   <= 1'b1;
         s_r.mon        <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs from flops; o_power_down decoded from the power mode, o_phase_cmp and o_pready constant
   assign o_pump                = s_r.pump;
   assign o_pump_oe_n           = s_r.pump_oe_n;
   assign o_phase_ref           = s_r.phr;
   assign o_phase_cmp           = 1'b0;
   assign o_phase_cmp_oe_n      = s_r.php_oe_n;
   assign o_lock_or_monitor_pin = s_r.mon;
   assign o_prescaler_32        = s_r.ref_lat[pdm_pkg::REF_SW_BIT];
   assign o_ref_ratio           = s_r.ref_lat[pdm_pkg::REF_R_W-1:pdm_pkg::REF_R_LSB];
   assign o_swallow             = s_r.div_lat[pdm_pkg::DIV_N_LSB-1:pdm_pkg::DIV_A_LSB];
   assign o_prog_count          = s_r.div_lat[pdm_pkg::DIV_W-1:pdm_pkg::DIV_N_LSB];
   assign o_power_down          = (s_r.pwr == pdm_pkg::PM_SAVE);
   assign o_pready              = 1'b1;
   assign o_prdata              = s_r.prdata;
   assign o_pslverr             = s_r.pslverr;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);

   property p_presc;
      (s_r.s2[pdm_pkg::SY_LE] && s_r.sr[0]) |=> (o_prescaler_32 == $past(s_r.sr[15]));
   endproperty
   a_presc: assert property (p_presc) else $error("prescaler select not loaded");

   property p_lock_sel;
      (!monitor_output_select && !run) |=> o_lock_or_monitor_pin;
   endproperty
   a_lock_sel: assert property (p_lock_sel) else $error("lock not shown");

   property p_pol_hi;
      (fc && run && pd.ref_lead && s_r.s2[pdm_pkg::SY_ZC])
         |=> (o_pump && !o_pump_oe_n && !o_phase_ref && !o_phase_cmp_oe_n);
   endproperty
   a_pol_hi: assert property (p_pol_hi) else $error("polarity high response wrong");

   property p_pol_lo;
      (!fc && run && pd.ref_lead && s_r.s2[pdm_pkg::SY_ZC])
         |=> (!o_pump && !o_pump_oe_n && o_phase_ref && o_phase_cmp_oe_n);
   endproperty
   a_pol_lo: assert property (p_pol_lo) else $error("polarity low response wrong");

   property p_equal;
      (!pd.ref_lead && !pd.cmp_lead) |=> (o_pump_oe_n && !o_phase_ref && o_phase_cmp_oe_n);
   endproperty
   a_equal: assert property (p_equal) else $error("equal state not idle");

   property p_mon;
      (monitor_output_select && fc) |=> (o_lock_or_monitor_pin == $past(s_r.s2[pdm_pkg::SY_FR]));
   endproperty
   a_mon: assert property (p_mon) else $error("monitor not divided reference");

   property p_save;
      !s_r.s2[pdm_pkg::SY_PS] |=> (o_power_down ##1 o_pump_oe_n);
   endproperty
   a_save: assert property (p_save) else $error("power save not entered");

   property p_wake;
      (s_r.pwr == pdm_pkg::PM_WAKE) |-> (!pd.ref_lead && !pd.cmp_lead && o_pump_oe_n);
   endproperty
   a_wake: assert property (p_wake) else $error("error output during wake-up");

   property p_zc;
      !s_r.s2[pdm_pkg::SY_ZC] |=> o_pump_oe_n;
   endproperty
   a_zc: assert property (p_zc) else $error("pump driven while disabled");

   property p_shift;
      (s_r.s2[pdm_pkg::SY_SCLK] && !s_r.s3[pdm_pkg::SY_SCLK])
         |=> (s_r.sr == {$past(s_r.sr[17:0]), $past(s_r.s2[pdm_pkg::SY_DATA])});
   endproperty
   a_shift: assert property (p_shift) else $error("serial shift wrong");

   property p_div_load;
      (s_r.s2[pdm_pkg::SY_LE] && !s_r.sr[0]) |=> (s_r.div_lat == $past(s_r.sr[18:1]));
   endproperty
   a_div_load: assert property (p_div_load) else $error("divider latch not loaded");

   property p_hold;
      !s_r.s2[pdm_pkg::SY_LE] |=> ($stable(s_r.ref_lat) && $stable(s_r.div_lat));
   endproperty
   a_hold: assert property (p_hold) else $error("latch changed without load");

   c_wake: cover property ($rose(s_r.pwr == pdm_pkg::PM_WAKE) ##[1:200] run);
   c_lead: cover property (run && pd.ref_lead ##[1:40] run && pd.cmp_lead);
   c_save_load: cover property (!run && s_r.s2[pdm_pkg::SY_LE] && s_r.sr[0]);

endmodule // pdm_mode_ctrl

/* shared/pdm_pkg.sv */
// Constants, field layout and state codes of the PLL mode control block
package pdm_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // APB register byte offsets
   localparam logic [7:0]  OFF_CTRL       = 8'h00;   // Control, read/write
   localparam logic [7:0]  OFF_WAKE_LEN   = 8'h04;   // Wake limit length, read/write
   localparam logic [7:0]  OFF_STATUS     = 8'h08;   // Live state, read only
   localparam logic [7:0]  OFF_REF_LATCH  = 8'h0c;   // Reference latch, read only
   localparam logic [7:0]  OFF_DIV_LATCH  = 8'h10;   // Divider latch, read only

   // Control register field and reset value
   localparam int          CTRL_LIMIT_BIT = 0;       // Wake-up error limit enable
   localparam logic        CTRL_LIMIT_RST = 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // Serial word layout; the control bit is the last bit shifted in
   localparam int          SR_W           = 19;
   localparam int          REF_W          = 17;
   localparam int          DIV_W          = 18;
   localparam int          REF_R_LSB      = 0;
   localparam int          REF_R_W        = 14;
   localparam int          REF_SW_BIT     = 14;      // prescaler_modulus_select
   localparam int          REF_FC_BIT     = 15;      // phase_polarity_bit
   localparam int          REF_LDS_BIT    = 16;      // monitor_output_select
   localparam int          DIV_A_LSB      = 0;
   localparam int          DIV_A_W        = 7;
   localparam int          DIV_N_LSB      = 7;
   localparam int          DIV_N_W        = 11;
   localparam logic [16:0] REF_RST        = 17'h00000;
   localparam logic [17:0] DIV_RST        = 18'h00000;

   ////////////////////////////////////////////////////////////////////////////////
   // Synchroniser lane positions
   localparam int          SY_W           = 7;
   localparam int          SY_SCLK        = 0;
   localparam int          SY_DATA        = 1;
   localparam int          SY_LE          = 2;
   localparam int          SY_PS          = 3;
   localparam int          SY_ZC          = 4;
   localparam int          SY_FR          = 5;
   localparam int          SY_FP          = 6;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int          CLK_PERIOD_NS  = 100;
   localparam int          WAKE_TIME_NS   = 10000;   // Least wake-up limit time
   localparam logic [15:0] WAKE_CYC       =
      16'((WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int          LOCK_TIME_NS   = 1600;    // Least quiet time for lock
   localparam logic [7:0]  LOCK_CYC       =
      8'((LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Power mode, one-hot
   typedef enum logic [2:0]
   {
      PM_SAVE = 3'b001,
      PM_WAKE = 3'b010,
      PM_RUN  = 3'b100
   } pdm_pwr_t;

endpackage

/* shared/pdm_pd_if.sv */
// Carrier between the mode controller and the phase/frequency detector
`timescale 1ns/1ps
interface pdm_pd_if;
   logic ref_edge;   // Divided reference rising edge
   logic cmp_edge;   // Divided comparison rising edge
   logic clr;        // Hold detector idle
   logic ref_lead;   // Reference ahead
   logic cmp_lead;   // Comparison ahead

   modport ctrl (output ref_edge, output cmp_edge, output clr,
                 input ref_lead, input cmp_lead);
   modport det  (input ref_edge, input cmp_edge, input clr,
                 output ref_lead, output cmp_lead);
endinterface

/* logic/pdm_phase_det.sv */
// Phase/frequency detector with lead flags for reference and comparison
`timescale 1ns/1ps
module pdm_phase_det
(
   input  wire logic i_clk_sys,   // System clock
   input  wire logic i_arst_n,    // Async reset, active low
   pdm_pd_if.det     pd           // Edges in, lead flags out
);

   typedef struct packed
   {
      logic up;
      logic dn;
   } pdm_pd_st_t;

   pdm_pd_st_t s_r;
   pdm_pd_st_t s_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // Edge sets a flag; both set cancel, so equal rates leave it idle
   always_comb
   begin
      s_nxt    = s_r;
      s_nxt.up = s_r.up | pd.ref_edge;
      s_nxt.dn = s_r.dn | pd.cmp_edge;
      if ((s_nxt.up & s_nxt.dn) | pd.clr)
      begin
         s_nxt = '0;
      end
   end

   // State register
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign pd.ref_lead = s_r.up;
   assign pd.cmp_lead = s_r.dn;

   property p_lead_excl;
      @(posedge i_clk_sys) disable iff (!i_arst_n) !(s_r.up && s_r.dn);
   endproperty
   a_lead_excl: assert property (p_lead_excl) else $error("both lead flags set");

   // Hold request must empty both flags by the next edge
   property p_clr_idle;
      @(posedge i_clk_sys) disable iff (!i_arst_n) pd.clr |=> (!s_r.up && !s_r.dn);
   endproperty
   a_clr_idle: assert property (p_clr_idle) else $error("detector not held idle");

endmodule // pdm_phase_det

/* tb/pdm_host_model.sv */
// Host controller model: serial programming and mode pins
`timescale 1ns/1ps
module pdm_host_model
(
   input  wire logic i_clk_sys,  // System clock
   output logic      o_ser_clk,  // Serial clock, still between frames
   output logic      o_ser_data, // Serial data
   output logic      o_le,       // Load enable
   output logic      o_ps_n,     // Low = power save
   output logic      o_zc_n      // Low = pump floats
);
   // Power save held low from power-on, pins idle
   initial
   begin
      o_ps_n     = 1'b0;
      o_ser_clk  = 1'b0;
      o_ser_data = 1'b0;
      o_le       = 1'b0;
      o_zc_n     = 1'b1;
   end
   ////////////////////////////////////////
   // Wait whole cycles
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   // Mode pins; release of save is left to the bench, well after power-on
   task automatic set_pins(input logic ps_n, input logic zc_n);
      @(posedge i_clk_sys);
      o_ps_n <= ps_n;
      o_zc_n <= zc_n;
   endtask
   // MSB first, 3-cycle levels for the synchroniser, then load
   task automatic send(input logic [18:0] w);
      for (int i = 18; i >= 0; i--)
      begin
         @(posedge i_clk_sys);
         o_ser_data <= w[i];
         tick(3);
         o_ser_clk <= 1'b1;
         tick(3);
         o_ser_clk <= 1'b0;
      end
      tick(3);
      o_le <= 1'b1;
      tick(4);
      o_le       <= 1'b0;
      o_ser_data <= ~w[0];
      tick(2);
   endtask
endmodule // pdm_host_model

/* tb/pdm_mode_ctrl_tb.sv */
// Self-checking bench of the PLL mode controller
`timescale 1ns/1ps
module pdm_mode_ctrl_tb;
   logic        clk = 1'b0, arst_n = 1'b0, fr = 1'b0, fp = 1'b0, e, ph_cmp;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, q, prdata;
   logic        sclk, sdata, le, ps_n, zc_n, pump, pump_oe_n, ph_ref, ph_oe_n, mon, p32, pd;
   logic [13:0] ratio, r;
   logic [6:0]  swl;
   logic [10:0] cnt;
   logic [17:0] dw;
   int          n_errors = 0, tests_run = 0, cyc = 0, seed = 32'h87cc;

   always #50 clk = ~clk;

   pdm_host_model host
   (
      .i_clk_sys(clk), .o_ser_clk(sclk), .o_ser_data(sdata), .o_le(le), .o_ps_n(ps_n),
      .o_zc_n(zc_n)
   );
   pdm_mode_ctrl DUT
   (
      .i_clk_sys(clk), .i_arst_n(arst_n), .i_ser_clk(sclk), .i_ser_data(sdata),
      .i_load_enable_pin(le), .i_power_save_pin_n(ps_n), .i_pump_output_disable_pin_n(zc_n),
      .i_divided_reference_freq(fr), .i_divided_comparison_freq(fp), .o_pump(pump),
      .o_pump_oe_n(pump_oe_n), .o_phase_ref(ph_ref), .o_phase_cmp(ph_cmp),
      .o_phase_cmp_oe_n(ph_oe_n),
      .o_lock_or_monitor_pin(mon), .o_prescaler_32(p32), .o_ref_ratio(ratio), .o_swallow(swl),
      .o_prog_count(cnt), .o_power_down(pd), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr)
   );
   ////////////////////////////////////////
   task automatic report_and_stop;
      if (n_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer; result left in q and e
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // {pump_oe_n, pump, phase_ref, phase_cmp_oe_n}; st 2 ref ahead, 1 cmp ahead, 0 equal
   function automatic logic [3:0] pfd_exp(input logic f, input int st);
      if (st == 0)
         return 4'b1001;
      return ((st == 2) == f) ? 4'b0100 : 4'b0011;
   endfunction
   // One rising edge on one divided input, monitor sampled while high
   task automatic pulse(input logic to_ref, input logic f);
      @(posedge clk);
      fr <= to_ref;
      fp <= ~to_ref;
      repeat (6) @(posedge clk);
      chk(mon, f ? fr : fp);
      fr <= 1'b0;
      fp <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   // Hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         n_errors++;
         report_and_stop;
      end
   end
   ////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      chk({pd, pump_oe_n, mon}, 3'b111);
      chk({pready, ph_cmp}, 2'b10);
      apb(1'b0, pdm_pkg::OFF_CTRL, 32'h0);
      chk(q, 32'(pdm_pkg::CTRL_LIMIT_RST));
      apb(1'b0, 8'h14, 32'h0);
      chk(q, 32'h0);
      chk(e, 1'b1);
      apb(1'b1, pdm_pkg::OFF_STATUS, 32'h0);
      chk(e, 1'b1);
      // Loads taken while still in power save
      r = 14'($random(seed));
      host.send({1'b0, 3'b111, r, 1'b1});
      chk({p32, ratio}, {1'b1, r});
      apb(1'b0, pdm_pkg::OFF_REF_LATCH, 32'h0);
      chk(q, {15'h0, 3'b111, r});
      dw = 18'($random(seed));
      host.send({dw, 1'b0});
      chk({cnt, swl}, dw);
      chk({p32, ratio}, {1'b1, r});
      // Wake with a long limit so an edge lands inside it
      apb(1'b1, pdm_pkg::OFF_WAKE_LEN, 32'h28);
      host.set_pins(1'b1, 1'b1);
      repeat (4) @(posedge clk);
      fr <= 1'b1;
      repeat (6) @(posedge clk);
      fr <= 1'b0;
      repeat (4) @(posedge clk);
      chk(pump_oe_n, 1'b1);
      repeat (40) @(posedge clk);
      chk({pd, pump_oe_n}, 2'b01);
      for (int f = 1; f >= 0; f--)
      begin
         if (f == 0)
         begin
            host.send({1'b0, 3'b100, r, 1'b1});
            chk(p32, 1'b0);
         end
         for (int k = 0; k < 4; k++)
         begin
            pulse(k == 0 || k == 3, f[0]);
            chk({pump_oe_n, pump & ~pump_oe_n, ph_ref, ph_oe_n},
                pfd_exp(f[0], k == 0 ? 2 : (k == 2 ? 1 : 0)));
         end
      end
      // Disable pin floats a driving pump
      pulse(1'b1, 1'b0);
      host.set_pins(1'b1, 1'b0);
      repeat (6) @(posedge clk);
      chk(pump_oe_n, 1'b1);
      host.set_pins(1'b1, 1'b1);
      repeat (6) @(posedge clk);
      chk(pump_oe_n, 1'b0);
      // Lock select, then save while the pump would drive
      host.send({1'b0, 3'b000, r, 1'b1});
      chk(mon, 1'b0);
      host.set_pins(1'b0, 1'b1);
      repeat (6) @(posedge clk);
      chk({pd, pump_oe_n, mon}, 3'b111);
      report_and_stop;
   end
endmodule // pdm_mode_ctrl_tb
